// ==== pllc_core.v ====
// Purpose: Integer-N synthesizer digital core with APB registers
// Assumes: ref_clk_in and vco_clk_in are well below pclk/2 after any analog divide
// Notes: Reference and VCO edges are synchronised and used as enables on pclk
`timescale 1ns/100ps
`include "pllc_consts.vh"
// Operation
// - Reference divided by 10-bit R feeds detector
// - Prescaler base 16 or 19, divides P/P+1
// - Prescaler built on 4/5 core per step
// - 5-bit swallow and 12-bit main counters
// - Feedback ratio equals B times P plus A
// - Detector makes up/down from phase error
// - Anti-backlash minimum width on both outputs
// - Lock when edges within one pclk cycle
// - Lock output high locked, low unlocked
// - Pump sources on up, sinks on down
// - 3-bit pump current select, eight levels
// - Code k gives k plus one units
// - Pump and tuning forced mid during calibration
// - Strap chooses two-wire or four-wire port
// - Powered-down state when unused
module pllc_core (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ref_clk_in,
    input wire vco_clk_in,
    input wire config_port_strap,
    output reg config_port_four_wire,
    output reg pump_source_en,
    output reg pump_sink_en,
    output reg pump_force_half_supply,
    output reg vco_tuning_node_force_mid,
    output reg pump_current_sel_msb,
    output reg pump_current_sel_mid,
    output reg pump_current_sel_lsb,
    output reg [3:0] pump_current_units,
    output reg lock_detect,
    output reg synth_powered_down
);
    // Register storage
    reg pd;
    reg base19;
    reg [2:0] cp_sel;
    reg [9:0] r_ratio;
    reg [4:0] a_ratio;
    reg [11:0] b_ratio;
    reg cal_busy;
    reg [2:0] cal_cnt;

    // Pin synchronisers: stage one feeds stage two only
    reg [2:0] sync1;
    reg [2:0] sync2;
    reg ref_prev;
    reg vco_prev;
    reg [1:0] strap_wait;
    reg strap_done;

    // Divider state
    reg [9:0] r_cnt;
    reg ref_pulse;
    reg [4:0] a_rem;
    reg [11:0] b_rem;
    reg fb_pulse;

    wire ref_tick;
    wire vco_tick;
    wire pre_pulse;
    wire mod_hi;
    wire div_run;
    wire pfd_up;
    wire pfd_down;
    wire pfd_locked;
    wire [9:0] r_last;
    wire setup_phase;
    wire wr_en;
    wire addr_ok;

    function hit;
        input [11:0] addr;
        input [11:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // APB: zero wait states, unmapped addresses answer with an error
    assign setup_phase = psel && !penable;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign addr_ok = hit(paddr, `PLLC_OFF_CTRL) || hit(paddr, `PLLC_OFF_RDIV) ||
                     hit(paddr, `PLLC_OFF_NDIV) || hit(paddr, `PLLC_OFF_STAT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd <= `PLLC_RST_PD;
            base19 <= `PLLC_RST_P19;
            cp_sel <= `PLLC_RST_CP;
            r_ratio <= `PLLC_RST_RDIV;
            a_ratio <= `PLLC_RST_A;
            b_ratio <= `PLLC_RST_B;
        end else if (wr_en) begin
            if (hit(paddr, `PLLC_OFF_CTRL)) begin
                pd <= pwdata[`PLLC_CTRL_PD_BIT];
                base19 <= pwdata[`PLLC_CTRL_P19_BIT];
                cp_sel <= pwdata[`PLLC_CTRL_CP_MSB:`PLLC_CTRL_CP_LSB];
            end
            if (hit(paddr, `PLLC_OFF_RDIV)) begin
                r_ratio <= pwdata[`PLLC_RDIV_MSB:0];
            end
            if (hit(paddr, `PLLC_OFF_NDIV)) begin
                a_ratio <= pwdata[`PLLC_NDIV_A_MSB:`PLLC_NDIV_A_LSB];
                b_ratio <= pwdata[`PLLC_NDIV_B_MSB:`PLLC_NDIV_B_LSB];
            end
        end
    end

    // Read data is prepared in the setup phase and held through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase) begin
            prdata <= 32'h00000000;
            if (hit(paddr, `PLLC_OFF_CTRL)) begin
                prdata[`PLLC_CTRL_PD_BIT] <= pd;
                prdata[`PLLC_CTRL_P19_BIT] <= base19;
                prdata[`PLLC_CTRL_CAL_BIT] <= cal_busy;
                prdata[`PLLC_CTRL_CP_MSB:`PLLC_CTRL_CP_LSB] <= cp_sel;
            end
            if (hit(paddr, `PLLC_OFF_RDIV)) begin
                prdata[`PLLC_RDIV_MSB:0] <= r_ratio;
            end
            if (hit(paddr, `PLLC_OFF_NDIV)) begin
                prdata[`PLLC_NDIV_A_MSB:`PLLC_NDIV_A_LSB] <= a_ratio;
                prdata[`PLLC_NDIV_B_MSB:`PLLC_NDIV_B_LSB] <= b_ratio;
            end
            if (hit(paddr, `PLLC_OFF_STAT)) begin
                prdata[`PLLC_STAT_LOCK_BIT] <= lock_detect;
                prdata[`PLLC_STAT_CAL_BIT] <= cal_busy;
                prdata[`PLLC_STAT_STRAP_BIT] <= config_port_four_wire;
                prdata[`PLLC_STAT_PD_BIT] <= pd;
            end
        end
    end

    // Two-stage synchronisers for reference, VCO and strap pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            ref_prev <= 1'b0;
            vco_prev <= 1'b0;
        end else begin
            sync1 <= {config_port_strap, vco_clk_in, ref_clk_in};
            sync2 <= sync1;
            ref_prev <= sync2[0];
            vco_prev <= sync2[1];
        end
    end

    assign ref_tick = sync2[0] && !ref_prev;
    assign vco_tick = sync2[1] && !vco_prev;

    // Strap is caught once, after the synchroniser has filled following reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_wait <= 2'h0;
            strap_done <= 1'b0;
            config_port_four_wire <= 1'b0;
        end else if (!strap_done) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == 2'h3) begin
                strap_done <= 1'b1;
                config_port_four_wire <= sync2[2];
            end
        end
    end

    assign div_run = !pd;

    // Reference divider; ratios 0 and 1 both pass every edge
    assign r_last = (r_ratio <= 10'h001) ? 10'h000 : (r_ratio - 10'h001);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_cnt <= 10'h000;
            ref_pulse <= 1'b0;
        end else if (!div_run) begin
            r_cnt <= 10'h000;
            ref_pulse <= 1'b0;
        end else begin
            ref_pulse <= 1'b0;
            if (ref_tick) begin
                if (r_cnt >= r_last) begin
                    r_cnt <= 10'h000;
                    ref_pulse <= 1'b1;
                end else begin
                    r_cnt <= r_cnt + 10'h001;
                end
            end
        end
    end

    // Swallow counter keeps the prescaler at P+1 until it runs out
    assign mod_hi = (a_rem != 5'h00);

    pllc_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .enable(div_run),
        .vco_tick(vco_tick),
        .base19(base19),
        .mod_hi(mod_hi),
        .out_pulse(pre_pulse)
    );

    // Main counter spans B prescaler periods, giving N = B*P + A
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_rem <= `PLLC_RST_A;
            b_rem <= `PLLC_RST_B;
            fb_pulse <= 1'b0;
        end else if (!div_run) begin
            a_rem <= a_ratio;
            b_rem <= b_ratio;
            fb_pulse <= 1'b0;
        end else begin
            fb_pulse <= 1'b0;
            if (pre_pulse) begin
                if (b_rem <= 12'h001) begin
                    a_rem <= a_ratio;
                    b_rem <= b_ratio;
                    fb_pulse <= 1'b1;
                end else begin
                    b_rem <= b_rem - 12'h001;
                    if (a_rem != 5'h00) begin
                        a_rem <= a_rem - 5'h01;
                    end
                end
            end
        end
    end

    pllc_pfd u_pfd (
        .pclk(pclk),
        .presetn(presetn),
        .enable(div_run),
        .ref_pulse(ref_pulse),
        .fb_pulse(fb_pulse),
        .up(pfd_up),
        .down(pfd_down),
        .locked(pfd_locked)
    );

    // Calibration runs a fixed number of reference periods; a new start wins over the end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_busy <= 1'b0;
            cal_cnt <= 3'h0;
        end else if (wr_en && hit(paddr, `PLLC_OFF_CTRL) && pwdata[`PLLC_CTRL_CAL_BIT]) begin
            cal_busy <= 1'b1;
            cal_cnt <= 3'h0;
        end else if (cal_busy && (pd || (ref_pulse && (cal_cnt == `PLLC_CAL_PFD_PERIODS - 3'h1)))) begin
            cal_busy <= 1'b0;
            cal_cnt <= 3'h0;
        end else if (cal_busy && ref_pulse) begin
            cal_cnt <= cal_cnt + 3'h1;
        end
    end

    // Registered pump and status outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_source_en <= 1'b0;
            pump_sink_en <= 1'b0;
            pump_force_half_supply <= 1'b0;
            vco_tuning_node_force_mid <= 1'b0;
            pump_current_sel_msb <= 1'b0;
            pump_current_sel_mid <= 1'b0;
            pump_current_sel_lsb <= 1'b0;
            pump_current_units <= 4'h1;
            lock_detect <= 1'b0;
            synth_powered_down <= 1'b0;
        end else begin
            pump_source_en <= pfd_up && !cal_busy && div_run;
            pump_sink_en <= pfd_down && !cal_busy && div_run;
            pump_force_half_supply <= cal_busy;
            vco_tuning_node_force_mid <= cal_busy;
            pump_current_sel_msb <= cp_sel[2];
            pump_current_sel_mid <= cp_sel[1];
            pump_current_sel_lsb <= cp_sel[0];
            pump_current_units <= {1'b0, cp_sel} + 4'h1;
            lock_detect <= pfd_locked && div_run;
            synth_powered_down <= pd;
        end
    end
endmodule // pllc_core

// ==== pllc_consts.vh ====
// Purpose: Constants for the integer-N synthesizer digital core
// Assumes: 32-bit APB register bus, pclk at 50 MHz
// Notes: Offsets are byte addresses, one aligned word per register
`ifndef PLLC_CONSTS_VH
`define PLLC_CONSTS_VH

// Register offsets
`define PLLC_OFF_CTRL 12'h000
`define PLLC_OFF_RDIV 12'h004
`define PLLC_OFF_NDIV 12'h008
`define PLLC_OFF_STAT 12'h00c

// Control register fields
`define PLLC_CTRL_PD_BIT 0
`define PLLC_CTRL_P19_BIT 1
`define PLLC_CTRL_CAL_BIT 2
`define PLLC_CTRL_CP_LSB 4
`define PLLC_CTRL_CP_MSB 6

// Divider register fields
`define PLLC_RDIV_MSB 9
`define PLLC_NDIV_A_LSB 0
`define PLLC_NDIV_A_MSB 4
`define PLLC_NDIV_B_LSB 16
`define PLLC_NDIV_B_MSB 27

// Status register fields
`define PLLC_STAT_LOCK_BIT 0
`define PLLC_STAT_CAL_BIT 1
`define PLLC_STAT_STRAP_BIT 2
`define PLLC_STAT_PD_BIT 3

// Reset values
`define PLLC_RST_PD 1'b0
`define PLLC_RST_P19 1'b0
`define PLLC_RST_CP 3'h0
`define PLLC_RST_RDIV 10'h001
`define PLLC_RST_A 5'h00
`define PLLC_RST_B 12'h010

// Timing
`define PLLC_CLK_PERIOD_NS 20
`define PLLC_LOCK_WIN_NS 5
`define PLLC_ABL_CYC 2
`define PLLC_CAL_PFD_PERIODS 3'h7

`endif

// ==== pllc_prescaler.v ====
// Purpose: Dual-modulus prescaler P/P+1 with P of 16 or 19
// Assumes: vco_tick is a one-cycle pulse per synchronised VCO rising edge
// Notes: Four steps of a 4/5 core form one prescaler period
`timescale 1ns/100ps
module pllc_prescaler (
    input wire pclk,
    input wire presetn,
    input wire enable,
    input wire vco_tick,
    input wire base19,
    input wire mod_hi,
    output reg out_pulse
);
    reg [2:0] core_cnt;
    reg [1:0] step;
    wire core_div5;
    wire [2:0] core_last;

    // Base 19 runs three of four steps at 5; modulus input adds one more at the last step
    assign core_div5 = (base19 && (step != 2'h3)) || ((step == 2'h3) && mod_hi);
    assign core_last = core_div5 ? 3'h4 : 3'h3;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_cnt <= 3'h0;
            step <= 2'h0;
            out_pulse <= 1'b0;
        end else if (!enable) begin
            core_cnt <= 3'h0;
            step <= 2'h0;
            out_pulse <= 1'b0;
        end else begin
            out_pulse <= 1'b0;
            if (vco_tick) begin
                if (core_cnt == core_last) begin
                    core_cnt <= 3'h0;
                    step <= step + 2'h1;
                    if (step == 2'h3) begin
                        out_pulse <= 1'b1;
                    end
                end else begin
                    core_cnt <= core_cnt + 3'h1;
                end
            end
        end
    end
endmodule // pllc_prescaler

// ==== pllc_pfd.v ====
// Purpose: Phase frequency detector with anti-backlash pulse and lock detect
// Assumes: ref_pulse and fb_pulse are one-cycle pulses, never two in a row
// Notes: Lock window of 5 ns rounds up to one pclk cycle
`timescale 1ns/100ps
`include "pllc_consts.vh"
module pllc_pfd (
    input wire pclk,
    input wire presetn,
    input wire enable,
    input wire ref_pulse,
    input wire fb_pulse,
    output reg up,
    output reg down,
    output reg locked
);
    localparam LOCK_RAW = `PLLC_LOCK_WIN_NS / `PLLC_CLK_PERIOD_NS;
    localparam [7:0] LOCK_CYC = (LOCK_RAW < 1) ? 8'h01 : LOCK_RAW[7:0];
    localparam integer ABL_RAW = `PLLC_ABL_CYC - 1;
    localparam [1:0] ABL_LAST = ABL_RAW[1:0];

    reg [1:0] abl_cnt;
    reg [7:0] gap;
    wire both;
    wire abl_clear;
    wire second_edge;

    assign both = up && down;
    assign abl_clear = both && (abl_cnt == ABL_LAST);
    // The later of the two edges closes the comparison
    assign second_edge = (ref_pulse && !up && (down || fb_pulse)) || (fb_pulse && !down && (up || ref_pulse));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up <= 1'b0;
            down <= 1'b0;
            abl_cnt <= 2'h0;
            gap <= 8'h00;
            locked <= 1'b0;
        end else if (!enable) begin
            up <= 1'b0;
            down <= 1'b0;
            abl_cnt <= 2'h0;
            gap <= 8'h00;
            locked <= 1'b0;
        end else begin
            // A new edge wins over the reset of the pair
            up <= (up && !abl_clear) || ref_pulse;
            down <= (down && !abl_clear) || fb_pulse;
            // Both outputs stay high together for a minimum width
            if (both && !abl_clear) begin
                abl_cnt <= abl_cnt + 2'h1;
            end else begin
                abl_cnt <= 2'h0;
            end
            if (up != down) begin
                if (gap != 8'hff) begin
                    gap <= gap + 8'h01;
                end
            end else begin
                gap <= 8'h00;
            end
            if (second_edge) begin
                locked <= (gap < LOCK_CYC);
            end
        end
    end
endmodule // pllc_pfd

// ==== pllc_core_monitor.sv ====
// Purpose: Port-level assertions for pllc_core
// Assumes: One pclk domain, presetn async active low
// Notes: Bound into every pllc_core instance
`timescale 1ns/100ps
module pllc_core_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    input wire pump_source_en,
    input wire pump_sink_en,
    input wire pump_force_half_supply,
    input wire vco_tuning_node_force_mid,
    input wire pump_current_sel_msb,
    input wire pump_current_sel_mid,
    input wire pump_current_sel_lsb,
    input wire [3:0] pump_current_units,
    input wire lock_detect,
    input wire synth_powered_down
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [2:0] sel = {pump_current_sel_msb, pump_current_sel_mid, pump_current_sel_lsb};
    wire ctrl_wr = psel && penable && pwrite && paddr == 12'h000;
    wire both = pump_source_en && pump_sink_en;
    chk_units_code: assert property (pump_current_units == {1'b0, sel} + 4'h1)
        else $error("pump units do not follow code");
    // Pin outputs follow the stored field one cycle after the write lands
    chk_sel_write: assert property (ctrl_wr |=> ##1 sel == $past(pwdata[6:4], 2))
        else $error("pump code not loaded");
    chk_sel_hold: assert property (!ctrl_wr ##1 !ctrl_wr |=> $stable(sel))
        else $error("pump code changed without write");
    chk_pd_write: assert property (ctrl_wr |=> ##1 synth_powered_down == $past(pwdata[0], 2))
        else $error("power-down not loaded");
    chk_pd_quiet: assert property (synth_powered_down [*3] |-> !lock_detect && !both && !pump_source_en)
        else $error("activity while powered down");
    chk_backlash_width: assert property ($rose(both) |=> both ##1 !(pump_source_en || pump_sink_en))
        else $error("anti-backlash width wrong");
    chk_cal_mid: assert property (pump_force_half_supply == vco_tuning_node_force_mid)
        else $error("force outputs disagree");
    chk_cal_off: assert property (pump_force_half_supply [*2] |-> !pump_source_en && !pump_sink_en)
        else $error("pump on during calibration");
    chk_err_map: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h00c))
        else $error("slave error on wrong address");
    cover property ($rose(lock_detect));
    cover property ($rose(both));
    cover property ($fell(pump_force_half_supply));
    cover property (pslverr);
endmodule // pllc_core_monitor

bind pllc_core pllc_core_monitor u_pllc_core_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pslverr, .pump_source_en, .pump_sink_en, .pump_force_half_supply, .vco_tuning_node_force_mid,
    .pump_current_sel_msb, .pump_current_sel_mid, .pump_current_sel_lsb, .pump_current_units, .lock_detect,
    .synth_powered_down);

// ==== pllc_osc_model.sv ====
// Purpose: Reference oscillator and VCO stand-in for pllc_core
// Assumes: Half periods of 100 ns, well above two pclk
// Notes: A stopped clock stands low; track_n ties ref to every Nth VCO edge
`timescale 1ns/100ps
module pllc_osc_model (
    input wire ref_run,
    input wire vco_run,
    input wire [15:0] track_n,
    output logic ref_clk_in,
    output logic vco_clk_in,
    output int ref_edges,
    output int vco_edges
);
    logic ref_free = 1'b0;
    logic ref_trk = 1'b0;
    int tc = 0;
    initial begin
        vco_clk_in = 1'b0;
        ref_edges = 0;
        vco_edges = 0;
    end
    always #100 vco_clk_in = vco_run & ~vco_clk_in;
    always #100 ref_free = ref_run & ~ref_free;
    assign ref_clk_in = track_n != 16'h0000 ? ref_trk : ref_free;
    always @(posedge vco_clk_in) begin
        vco_edges++;
        tc++;
        ref_trk = track_n != 16'h0000 && tc % track_n == 0;
    end
    always @(negedge vco_clk_in) ref_trk = 1'b0;
    always @(negedge vco_run) tc = 0;
    always @(posedge ref_clk_in) ref_edges++;
endmodule // pllc_osc_model

// ==== integer_n_pll_divider_core_test.sv ====
// Purpose: Self-checking bench for pllc_core
// Assumes: pclk 50 MHz, zero-wait APB slave
// Notes: Divider counts are read as oscillator edges before each pump rises
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module integer_n_pll_divider_core_test;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic config_port_strap = 1'b1, ref_run = 1'b0, vco_run = 1'b0, rerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [15:0] track_n = 16'h0000;
    wire [31:0] prdata;
    wire [3:0] pump_current_units;
    wire pready, pslverr, ref_clk_in, vco_clk_in, config_port_four_wire, pump_source_en, pump_sink_en;
    wire pump_force_half_supply, vco_tuning_node_force_mid, lock_detect, synth_powered_down;
    wire pump_current_sel_msb, pump_current_sel_mid, pump_current_sel_lsb;
    int fail_count = 0, total_checks = 0, cyc = 0, s, ref_edges, vco_edges;
    logic [11:0] ra [6] = '{12'h00c, 12'h004, 12'h008, 12'h010, 12'hffc, 12'h000};
    logic [31:0] rw [6] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h1, 32'h1, 32'h71};
    logic [31:0] rx [6] = '{32'h4, 32'h3ff, 32'h0fff001f, 32'h0, 32'h0, 32'h71};
    logic re [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    // Ratios kept legal for the host: A up to 31, B above A, N in range
    logic dp [3] = '{1'b0, 1'b1, 1'b0};
    logic [4:0] da [3] = '{5'h00, 5'h01, 5'h1f};
    logic [11:0] db [3] = '{12'h010, 12'h013, 12'h020};
    logic [9:0] dr [3] = '{10'h005, 10'h001, 10'h3ff};
    int dn [3] = '{256, 362, 543};

    pllc_core u_pllc_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ref_clk_in, .vco_clk_in, .config_port_strap, .config_port_four_wire, .pump_source_en,
        .pump_sink_en, .pump_force_half_supply, .vco_tuning_node_force_mid, .pump_current_sel_msb,
        .pump_current_sel_mid, .pump_current_sel_lsb, .pump_current_units, .lock_detect, .synth_powered_down);
    pllc_osc_model u_pllc_osc_model (.ref_run, .vco_run, .track_n, .ref_clk_in, .vco_clk_in, .ref_edges,
        .vco_edges);

    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            stop_test();
        end
    end

    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0); `CHK("rdiv_reset", 32'h1, rdat)
        apb(1'b0, 12'h008, 32'h0); `CHK("ndiv_reset", 32'h00100000, rdat)
        `CHK("units_reset", 4'h1, pump_current_units)
        `CHK("four_wire", 1'b1, config_port_four_wire)
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ra[i], rw[i]); `CHK("wr_err", re[i], rerr)
            apb(1'b0, ra[i], 32'h0); `CHK("rd_err", re[i], rerr)
            `CHK("rd_data", rx[i], rdat)
        end
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, 12'h000, {25'h0, k[2:0], 4'h1});
            @(posedge pclk);
            `CHK("pd_pin", 1'b1, synth_powered_down)
            `CHK("units", 4'(k + 1), pump_current_units)
            `CHK("sel", k[2:0], {pump_current_sel_msb, pump_current_sel_mid, pump_current_sel_lsb})
        end
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'h000, {30'h0, dp[i], 1'b1});
            apb(1'b1, 12'h008, {4'h0, db[i], 11'h0, da[i]});
            apb(1'b1, 12'h004, {22'h0, dr[i]});
            apb(1'b1, 12'h000, {30'h0, dp[i], 1'b0});
            s = vco_edges;
            vco_run <= 1'b1;
            @(posedge pclk iff pump_sink_en);
            vco_run <= 1'b0;
            `CHK("fb_edges", dn[i], vco_edges - s)
            s = ref_edges;
            ref_run <= 1'b1;
            @(posedge pclk iff pump_source_en);
            ref_run <= 1'b0;
            `CHK("ref_edges", int'(dr[i]), ref_edges - s)
            repeat (4) @(posedge pclk);
            `CHK("pumps", 2'b00, {pump_source_en, pump_sink_en})
            `CHK("unlocked", 1'b0, lock_detect)
        end
        $display("test dividers done");
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h008, 32'h00100000);
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        track_n <= 16'd256;
        vco_run <= 1'b1;
        @(posedge pclk iff pump_sink_en);
        repeat (2) @(posedge pclk);
        `CHK("locked", 1'b1, lock_detect)
        vco_run <= 1'b0;
        track_n <= 16'h0000;
        apb(1'b1, 12'h000, 32'h4);
        @(posedge pclk);
        `CHK("cal_force", 1'b1, pump_force_half_supply)
        `CHK("cal_tune", 1'b1, vco_tuning_node_force_mid)
        s = ref_edges;
        ref_run <= 1'b1;
        @(posedge pclk iff !pump_force_half_supply);
        ref_run <= 1'b0;
        `CHK("cal_len", 7, ref_edges - s)
        $display("test lock and calibration done");
        presetn <= 1'b0;
        config_port_strap <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK("two_wire", 1'b0, config_port_four_wire)
        apb(1'b0, 12'h00c, 32'h0); `CHK("stat", 32'h0, rdat)
        $display("test strap done");
        stop_test();
    end
endmodule // integer_n_pll_divider_core_test
